// ---- bench/dma_channel_trigger_control_test.sv ----
// self-checking bench for the dma channel trigger control block
// assumes the design package and the event source model are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module dma_channel_trigger_control_test;
    import dma_trig_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0, line = 4'h0;
    logic [31:0] dat = 32'h0, q, rdat;
    logic ack, mv, busy, done;
    logic [15:0] ev;
    int fails = 0, total_checks = 0, words = 0, dones = 0, k, m, len;

    always #10 clk_i = ~clk_i;

    evt_source_model u_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .line_i(line), .hw_event_o(ev));
    dma_channel_trigger_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .hw_event_i(ev), .word_move_o(mv), .busy_o(busy), .done_o(done));

    always @(posedge clk_i) begin
        if (mv === 1'b1) words++;
        if (done === 1'b1) dones++;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // wait for ack under a bound; data taken at the ack edge only
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) fails++;
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic pulse(input int ln);
        @(posedge clk_i);
        fire <= 1'b1; line <= 4'(ln);
        @(posedge clk_i);
        fire <= 1'b0;
    endtask : pulse

    // let a transfer begin, then wait until it is over
    task automatic settle;
        int n;
        n = 0;
        repeat (4) @(posedge clk_i);
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (busy !== 1'b0) fails++;
        repeat (3) @(posedge clk_i);
    endtask : settle

    task automatic clr;
        words = 0;
        dones = 0;
    endtask : clr

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h5943));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (m = 0; m < 4; m++) begin
            xfer(1'b0, 4'(m * 4), 32'h0);
            `CHK("reset value", 32'h0, q)
        end
        xfer(1'b0, 4'h2, 32'h0);
        `CHK("unmapped read", BAD_ADDR_DATA, q)
        for (m = 0; m < 3; m++) begin
            len = 4 * (1 + $urandom_range(15));
            clr();
            xfer(1'b1, OFF_LEN, 32'(len));
            xfer(1'b1, OFF_CTRL, 32'h1);
            settle();
            `CHK("sw words", len / 4, words)
            `CHK("done pulses", 1, dones)
            xfer(1'b1, OFF_CTRL, 32'h0);
        end
        clr();
        xfer(1'b1, OFF_LEN, 32'h400);
        xfer(1'b1, OFF_CTRL, 32'h1);
        repeat (10) @(posedge clk_i);
        xfer(1'b1, OFF_CTRL, 32'h0);
        settle();
        `CHK("sw abort", 1'b1, (words > 0 && words < 256))
        k = 1 + $urandom_range(13);
        xfer(1'b1, OFF_LEN, 32'h8);
        xfer(1'b1, OFF_EVSEL, 32'(k));
        for (m = 0; m < 4; m++) begin
            xfer(1'b1, OFF_CTRL, 32'(4 | m));
            clr();
            pulse(k);
            settle();
            `CHK("sync matrix", (m != 0) ? 2 : 0, words)
            xfer(1'b1, OFF_CTRL, 32'h0);
        end
        xfer(1'b1, OFF_CTRL, 32'h6);
        clr();
        pulse(k + 1);
        settle();
        `CHK("other line", 0, words)
        xfer(1'b1, OFF_CTRL, 32'h0);
        xfer(1'b1, OFF_EVSEL, 32'(EVT_NONE));
        clr();
        xfer(1'b1, OFF_CTRL, 32'h3);
        pulse(k);
        settle();
        `CHK("no source", 0, words)
        xfer(1'b1, OFF_CTRL, 32'h0);
        xfer(1'b1, OFF_EVSEL, 32'(k));
        xfer(1'b1, OFF_CTRL, 32'h3);
        clr();
        pulse(k);
        settle();
        `CHK("sw event", 2, words)
        xfer(1'b1, OFF_CTRL, 32'h0);
        xfer(1'b1, OFF_LEN, 32'h800);
        xfer(1'b1, OFF_CTRL, 32'h23);
        clr();
        pulse(k);
        repeat (9) @(posedge clk_i);
        xfer(1'b1, OFF_CTRL, 32'h22);
        repeat (5) @(posedge clk_i);
        `CHK("enable only", 1'b1, busy)
        xfer(1'b1, OFF_CTRL, 32'h20);
        settle();
        `CHK("whole burst", 0, words % 4)
        `CHK("stopped", 1'b1, (words < 512))
        stop_test();
    end
endmodule : dma_channel_trigger_control_test

// ---- bench/evt_source_model.sv ----
// event source model: drives one-cycle pulses on a chosen event line
// assumes fire_i and line_i change just after a rising edge of clk_i
`timescale 1ns/1ps
module evt_source_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [3:0] line_i,
    output logic [15:0] hw_event_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i || !fire_i) begin
            hw_event_o <= 16'h0000;
        end else begin
            hw_event_o <= 16'h0001 << line_i;
        end
    end
endmodule : evt_source_model

// ---- rtl/dma_burst_counter.sv ----
// burst word counter: counts the words of one burst and flags its last word
// assumes word_i is a single-cycle beat from the channel sequencer
`timescale 1ns/1ps
module dma_burst_counter
    import dma_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic word_i,
    input wire logic [CTRL_BURST_W-1:0] burst_mode_i,
    output logic last_o
);
    logic [4:0] cnt_r;
    logic [4:0] words;

    always_comb begin
        words = 5'(5'h01 << burst_mode_i);
        last_o = word_i && (cnt_r == 5'(words - 5'h01));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || start_i) begin
            cnt_r <= 5'h00;
        end else if (word_i) begin
            cnt_r <= last_o ? 5'h00 : 5'(cnt_r + 5'h01);
        end
    end
endmodule : dma_burst_counter

// ---- rtl/dma_channel_trigger_control.sv ----
// one dma channel's start/stop control with a wishbone register slave
// assumes hw_event_i comes from logic on clk_i; word moves are one per cycle while running
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module dma_channel_trigger_control
    import dma_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [(1<<EVT_W)-1:0] hw_event_i,
    output logic word_move_o,
    output logic busy_o,
    output logic done_o
);
    channel_transfer_control_2_t ctrl_r;
    logic [EVT_W-1:0] event_source_select_r;
    logic [LEN_W-1:0] len_r;
    logic [LEN_W-1:0] left_r;
    chan_state_t state_r;
    chan_state_t state_nxt;
    chan_status_t stat;
    logic hw_started_r;
    logic wr_ctrl;
    logic wb_req;
    logic evt_hit;
    logic sw_start;
    logic hw_start;
    logic start;
    logic burst_last;
    logic len_last;
    logic en_prev_r;
    logic stop_both;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == OFF_CTRL) && wb_sel_i[0];

    // bus answers one cycle after the request, for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= '0;
        end else if (wr_ctrl) begin
            ctrl_r.enable <= wb_dat_i[CTRL_EN_BIT];
            ctrl_r.auto_reload_bit <= wb_dat_i[CTRL_RELOAD_BIT];
            ctrl_r.hw_sync_select <= wb_dat_i[CTRL_SYNC_BIT];
            ctrl_r.burst_mode <= (wb_dat_i[CTRL_BURST_LSB +: CTRL_BURST_W] > BURST_MAX) ?
                BURST_MAX : wb_dat_i[CTRL_BURST_LSB +: CTRL_BURST_W];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_source_select_r <= EVT_NONE;
        end else if (wb_req && wb_we_i && (wb_adr_i == OFF_EVSEL) && wb_sel_i[0]) begin
            event_source_select_r <= wb_dat_i[EVT_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_r <= LEN_RST;
        end else if (wb_req && wb_we_i && (wb_adr_i == OFF_LEN)) begin
            if (wb_sel_i[0]) begin
                len_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                len_r[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    assign stat = '{busy: (state_r != ST_IDLE), hw_started: hw_started_r, done: done_o};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= BAD_ADDR_DATA;
        end else if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFF_CTRL: wb_dat_o <= 32'({ctrl_r.burst_mode, 1'b0, ctrl_r.hw_sync_select,
                    ctrl_r.auto_reload_bit, ctrl_r.enable});
                OFF_EVSEL: wb_dat_o <= 32'(event_source_select_r);
                OFF_LEN: wb_dat_o <= 32'(len_r);
                OFF_STAT: wb_dat_o <= 32'(stat);
                default: wb_dat_o <= BAD_ADDR_DATA;
            endcase
        end
    end

    assign evt_hit = (event_source_select_r != EVT_NONE) && hw_event_i[event_source_select_r];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_prev_r <= 1'b0;
        end else begin
            en_prev_r <= ctrl_r.enable;
        end
    end

    always_comb begin
        if (ctrl_r.hw_sync_select) begin
            hw_start = evt_hit && (ctrl_r.enable || ctrl_r.auto_reload_bit);
            sw_start = 1'b0;
        end else begin
            hw_start = evt_hit && ctrl_r.auto_reload_bit;
            sw_start = !ctrl_r.auto_reload_bit && ctrl_r.enable && !en_prev_r;
        end
        start = hw_start || sw_start;
    end

    assign stop_both = !ctrl_r.enable && !ctrl_r.auto_reload_bit;
    assign len_last = word_move_o && (left_r <= WORD_BYTES);

    dma_burst_counter u_burst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start && (state_r == ST_IDLE)),
        .word_i(word_move_o),
        .burst_mode_i(ctrl_r.burst_mode),
        .last_o(burst_last)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (len_last) begin
                    state_nxt = ST_IDLE;
                end else if (!hw_started_r && !ctrl_r.enable) begin
                    state_nxt = ST_IDLE;
                end else if (hw_started_r && stop_both) begin
                    state_nxt = burst_last ? ST_IDLE : ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (burst_last || len_last) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hw_started_r <= 1'b0;
        end else if (state_r == ST_IDLE && start) begin
            hw_started_r <= hw_start;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_r <= LEN_RST;
        end else if (state_r == ST_IDLE && start) begin
            left_r <= len_r;
        end else if (word_move_o) begin
            left_r <= 16'(left_r - WORD_BYTES);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_move_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            word_move_o <= (state_nxt != ST_IDLE);
            busy_o <= (state_nxt != ST_IDLE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
        end
    end

    a_hw_needs_arm: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && ctrl_r.hw_sync_select && stop_both) |=> (state_r == ST_IDLE))
        else $error("hw sync channel started with both bits clear");
    a_reload_overrides: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && ctrl_r.hw_sync_select && ctrl_r.auto_reload_bit && evt_hit)
        |=> (state_r == ST_RUN && busy_o))
        else $error("reload did not arm hw event");
    a_sw_enable_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && !ctrl_r.hw_sync_select && !ctrl_r.auto_reload_bit
        && ctrl_r.enable && !en_prev_r) |=> busy_o)
        else $error("enable rise did not start");
    a_no_src_no_run: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && !ctrl_r.hw_sync_select && ctrl_r.auto_reload_bit
        && event_source_select_r == EVT_NONE) |=> (state_r == ST_IDLE))
        else $error("started with no event source");
    a_enable_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_IDLE && !ctrl_r.hw_sync_select && ctrl_r.auto_reload_bit && !evt_hit)
        |=> (state_r == ST_IDLE))
        else $error("enable started reload channel");
    a_en_clear_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_RUN && hw_started_r && ctrl_r.auto_reload_bit && !len_last)
        |=> (state_r == ST_RUN))
        else $error("hw started run stopped by enable alone");
    a_drain_burst: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_DRAIN && !burst_last && !len_last) |=> (state_r == ST_DRAIN))
        else $error("burst cut short");
    a_len_halt: assert property (@(posedge clk_i) disable iff (rst_i)
        len_last |=> (state_r == ST_IDLE && done_o) ##1 (done_o == 1'b0))
        else $error("no halt at length");
    a_en_clear_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ST_RUN && !hw_started_r && !ctrl_r.enable) |=> (state_r == ST_IDLE) ##1 !busy_o)
        else $error("enable clear did not stop");

    c_hw_run: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_IDLE && hw_start ##1 state_r == ST_RUN);
    c_sw_run: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_IDLE && sw_start ##1 state_r == ST_RUN);
    c_drain: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_DRAIN ##1 state_r == ST_IDLE);
endmodule : dma_channel_trigger_control

// ---- rtl/dma_trig_pkg.sv ----
// constants and carrier types for the dma channel trigger control block
// assumes a classic wishbone master with 32-bit data and byte addresses
// Overview of operation
// - the mode select bit picks hardware-sync when one and software-control when zero.
// - in hardware-sync mode with auto reload set, an assigned event starts a transfer even with enable low.
// - in hardware-sync mode an event starts a transfer when enable or auto reload is one, never otherwise.
// - in software mode with auto reload clear, setting enable starts the transfer regardless of event source.
// - in software mode with auto reload set, enable is ignored and only the assigned event triggers.
// - in software mode with auto reload set and no event assigned, no transfer ever starts.
// - an event-started software-mode transfer stops before its programmed length only when both auto reload and enable are clear.
// - such a stop lets the burst in progress finish before halting.
// - in software mode with auto reload clear, the channel halts after moving the programmed length.
// - in software mode with auto reload clear, clearing enable mid-transfer stops the channel.
package dma_trig_pkg;
    localparam int ADDR_W = 4;
    localparam int EVT_W = 4;
    localparam int LEN_W = 16;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_EVSEL = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_LEN = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STAT = 4'hC;
    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RELOAD_BIT = 1;
    localparam int CTRL_SYNC_BIT = 2;
    localparam int CTRL_BURST_LSB = 4;
    localparam int CTRL_BURST_W = 3;
    // event select: zero means no event assigned
    localparam logic [EVT_W-1:0] EVT_NONE = 4'h0;
    localparam logic [LEN_W-1:0] LEN_RST = 16'h0000;
    localparam logic [2:0] BURST_MAX = 3'h4;
    localparam logic [LEN_W-1:0] WORD_BYTES = 16'h0004;
    localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DRAIN
    } chan_state_t;

    typedef struct packed {
        logic hw_sync_select;
        logic auto_reload_bit;
        logic enable;
        logic [CTRL_BURST_W-1:0] burst_mode;
    } channel_transfer_control_2_t;

    typedef struct packed {
        logic busy;
        logic hw_started;
        logic done;
    } chan_status_t;
endpackage : dma_trig_pkg
